// ==== sim/dipc_fe_model.sv ====
// partner model: fetch/decode stage driving both decode slots and hazard state
`timescale 1ns/1ps
module dipc_fe_model
   import dipc_pkg::*;
(
   // clock
   input  wire logic            clk_i,
   // decode slots
   output logic                 dec_valid_o,
   output dipc_pkg::dipc_cls_t  first_cls_o,
   output logic [4:0]           first_dst_o,
   output logic                 first_unaligned_tgt_o,
   output logic                 second_valid_o,
   output dipc_pkg::dipc_cls_t  second_cls_o,
   output logic [4:0]           second_dst_o,
   // hazard state
   output logic                 ep_wb_pend_o,
   output logic                 prev_flag_upd_o,
   output logic [1:0]           ldbuf_wb_wait_o
);
   initial begin
      {dec_valid_o, second_valid_o, first_dst_o, second_dst_o} = '0;
      {first_unaligned_tgt_o, ep_wb_pend_o, prev_flag_upd_o, ldbuf_wb_wait_o} = '0;
      first_cls_o = DIPC_CLS_NOP;
      second_cls_o = DIPC_CLS_NOP;
   end
   // hz packs unaligned target, element pointer pending, flag update, load buffers
   task automatic put(input dipc_cls_t a, input logic [4:0] ad, input dipc_cls_t b, input logic [4:0] bd,
                      input logic [4:0] hz);
      @(posedge clk_i);
      #1;
      {dec_valid_o, second_valid_o} = 2'h3;
      first_cls_o = a;
      first_dst_o = ad;
      second_cls_o = b;
      second_dst_o = bd;
      {first_unaligned_tgt_o, ep_wb_pend_o, prev_flag_upd_o, ldbuf_wb_wait_o} = hz;
   endtask : put
   task automatic idle;
      @(posedge clk_i);
      #1;
      {dec_valid_o, second_valid_o} = 2'h0;
   endtask : idle
endmodule : dipc_fe_model

// ==== sim/tb.sv ====
// testbench: pairing decisions and breakpoint resume stepping
`timescale 1ns/1ps
module tb;
   import dipc_pkg::*;
   logic            clk, rst_n, resume, ce, pi, io, sdone, sact;
   wire logic       dv, ua, sv, ep, pf;
   wire dipc_cls_t  fc, sc;
   wire logic [4:0] fd, sd;
   wire logic [1:0] lb;
   logic [1:0]      adv;
   dipc_pk_t        pk;
   int              n_mismatch = 0;
   int              n_tests = 0;
   dipc_fe_model fe (.clk_i(clk), .dec_valid_o(dv), .first_cls_o(fc), .first_dst_o(fd), .first_unaligned_tgt_o(ua),
      .second_valid_o(sv), .second_cls_o(sc), .second_dst_o(sd), .ep_wb_pend_o(ep), .prev_flag_upd_o(pf),
      .ldbuf_wb_wait_o(lb));
   dipc_pair_ctrl DUT (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .dec_valid_i(dv), .first_cls_i(fc),
      .first_dst_i(fd), .first_unaligned_tgt_i(ua), .second_valid_i(sv), .second_cls_i(sc), .second_dst_i(sd),
      .ep_wb_pend_i(ep), .prev_flag_upd_i(pf), .ldbuf_wb_wait_i(lb), .resume_i(resume), .pair_issue_o(pi),
      .pair_kind_o(pk), .issue_o(io), .step_adv_o(adv), .step_done_o(sdone), .step_active_o(sact));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic conclude;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude
   task automatic chk_pair(input dipc_pk_t k);
      n_tests++;
      if (pi !== (k != DIPC_PK_NONE) || pk !== k || io !== 1'b1 || adv !== ((k != DIPC_PK_NONE) ? 2'h2 : 2'h1)) begin
         n_mismatch++;
         $display("unexpected at %0t: pair result for %s", $time, k.name());
      end
   endtask : chk_pair
   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: step flag", $time);
      end
   endtask : chk_bit
   task automatic run(input dipc_cls_t a, input logic [4:0] ad, input dipc_cls_t b, input logic [4:0] bd,
                      input logic [4:0] hz, input dipc_pk_t k);
      fe.put(a, ad, b, bd, hz);
      @(negedge clk);
      chk_pair(k);
   endtask : run
   task automatic t_fuse;
      dipc_cls_t l[5] = '{DIPC_CLS_SAT, DIPC_CLS_LOGIC, DIPC_CLS_ADDSUB, DIPC_CLS_SHIFT, DIPC_CLS_MULH};
      foreach (l[i]) run(DIPC_CLS_MOV_REG, 5'h05, l[i], 5'h05, 5'h00, DIPC_PK_FUSE);
      run(DIPC_CLS_MOV_REG, 5'h00, DIPC_CLS_ADDSUB, 5'h00, 5'h00, DIPC_PK_NONE);
      run(DIPC_CLS_MOV_REG, 5'h05, DIPC_CLS_SHIFT, 5'h06, 5'h00, DIPC_PK_NONE);
      run(DIPC_CLS_ADDSUB, 5'h05, DIPC_CLS_MOV_REG, 5'h05, 5'h00, DIPC_PK_NONE);
   endtask : t_fuse
   task automatic t_ubr;
      dipc_cls_t l[12] = '{DIPC_CLS_NOP, DIPC_CLS_MOV_REG, DIPC_CLS_NOT, DIPC_CLS_SLD, DIPC_CLS_SAT, DIPC_CLS_LOGIC,
         DIPC_CLS_TST, DIPC_CLS_ADDSUB, DIPC_CLS_CMP, DIPC_CLS_SHIFT, DIPC_CLS_MULH, DIPC_CLS_SST};
      foreach (l[i]) run(l[i], 5'h01, DIPC_CLS_UBR, 5'h02, 5'h00, DIPC_PK_UBR);
      run(DIPC_CLS_UBR, 5'h01, DIPC_CLS_NOP, 5'h02, 5'h00, DIPC_PK_NONE);
      run(DIPC_CLS_NOP, 5'h01, DIPC_CLS_UBR, 5'h02, 5'h10, DIPC_PK_NONE);
   endtask : t_ubr
   task automatic t_cbr;
      dipc_cls_t l[6] = '{DIPC_CLS_NOP, DIPC_CLS_MOV_REG, DIPC_CLS_SLD, DIPC_CLS_MULH, DIPC_CLS_EXT, DIPC_CLS_SST};
      dipc_cls_t f[4] = '{DIPC_CLS_NOT, DIPC_CLS_TST, DIPC_CLS_CMP, DIPC_CLS_ADDSUB};
      foreach (l[i]) run(l[i], 5'h01, DIPC_CLS_CBR, 5'h02, 5'h00, DIPC_PK_CBR);
      foreach (f[i]) run(f[i], 5'h01, DIPC_CLS_CBR, 5'h02, 5'h00, DIPC_PK_NONE);
      run(DIPC_CLS_NOP, 5'h01, DIPC_CLS_CBR, 5'h02, 5'h04, DIPC_PK_NONE);
   endtask : t_cbr
   task automatic t_sld;
      dipc_cls_t l[10] = '{DIPC_CLS_NOP, DIPC_CLS_MOV_REG, DIPC_CLS_NOT, DIPC_CLS_SAT, DIPC_CLS_LOGIC, DIPC_CLS_TST,
         DIPC_CLS_ADDSUB, DIPC_CLS_CMP, DIPC_CLS_SHIFT, DIPC_CLS_MULH};
      foreach (l[i]) run(l[i], 5'h01, DIPC_CLS_SLD, 5'h02, 5'h00, DIPC_PK_SLD);
      run(DIPC_CLS_NOP, 5'h01, DIPC_CLS_SLD, 5'h02, 5'h08, DIPC_PK_NONE);
      run(DIPC_CLS_NOP, 5'h01, DIPC_CLS_SLD, 5'h02, 5'h03, DIPC_PK_NONE);
      run(DIPC_CLS_NOP, 5'h01, DIPC_CLS_SLD, 5'h02, 5'h01, DIPC_PK_SLD);
      run(DIPC_CLS_SLD, 5'h01, DIPC_CLS_NOP, 5'h02, 5'h00, DIPC_PK_NONE);
   endtask : t_sld
   task automatic t_step;
      fe.idle();
      resume = 1'b1;
      @(posedge clk);
      #1;
      resume = 1'b0;
      @(negedge clk);
      chk_bit(sact, 1'b1);
      chk_bit(sdone, 1'b0);
      run(DIPC_CLS_MOV_REG, 5'h09, DIPC_CLS_ADDSUB, 5'h09, 5'h00, DIPC_PK_FUSE);
      chk_bit(sdone, 1'b1);
      fe.idle();
      @(negedge clk);
      chk_bit(sact, 1'b0);
      chk_bit(io, 1'b0);
      chk_bit(pi, 1'b0);
      chk_bit(adv == 2'h0, 1'b1);
   endtask : t_step
   task automatic t_hold;
      @(posedge clk);
      #1;
      resume = 1'b1;
      ce = 1'b0;
      @(posedge clk);
      #1;
      ce = 1'b1;
      @(negedge clk);
      chk_bit(sact, 1'b0);
      @(posedge clk);
      #1;
      resume = 1'b0;
      ce = 1'b0;
      run(DIPC_CLS_ADDSUB, 5'h01, DIPC_CLS_MOV_REG, 5'h01, 5'h00, DIPC_PK_NONE);
      chk_bit(sdone, 1'b1);
      fe.idle();
      @(negedge clk);
      chk_bit(sact, 1'b1);
      @(posedge clk);
      #1;
      ce = 1'b1;
      run(DIPC_CLS_ADDSUB, 5'h01, DIPC_CLS_MOV_REG, 5'h01, 5'h00, DIPC_PK_NONE);
      chk_bit(sdone, 1'b1);
      fe.idle();
      @(negedge clk);
      chk_bit(sact, 1'b0);
   endtask : t_hold
   task automatic t_rst;
      @(posedge clk);
      #1;
      resume = 1'b1;
      @(posedge clk);
      #1;
      resume = 1'b0;
      rst_n = 1'b0;
      @(negedge clk);
      chk_bit(sact, 1'b0);
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge clk);
      run(DIPC_CLS_NOP, 5'h01, DIPC_CLS_UBR, 5'h02, 5'h00, DIPC_PK_UBR);
      chk_bit(sact, 1'b0);
   endtask : t_rst
   initial begin
      rst_n = 1'b0;
      resume = 1'b0;
      ce = 1'b1;
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge clk);
      t_fuse();
      t_ubr();
      t_cbr();
      t_sld();
      t_step();
      t_hold();
      t_rst();
      conclude();
   end
   initial begin
      #100us;
      n_mismatch++;
      conclude();
   end
endmodule : tb

// ==== src/dipc_class_dec.sv ====
// class decoder: pairing eligibility of one instruction class
`timescale 1ns/1ps
module dipc_class_dec
   import dipc_pkg::*;
(
   // class in
   input  wire dipc_pkg::dipc_cls_t cls_i,
   // eligibility out
   output logic                     fuse_op_o,
   output logic                     pre_ubr_o,
   output logic                     pre_cbr_o,
   output logic                     pre_sld_o,
   output logic                     flag_upd_o
);
   import dipc_pkg::*;

   wire is_alu = (cls_i == DIPC_CLS_SAT) || (cls_i == DIPC_CLS_LOGIC) ||
                 (cls_i == DIPC_CLS_ADDSUB) || (cls_i == DIPC_CLS_SHIFT);
   wire is_mov = (cls_i == DIPC_CLS_MOV_REG) || (cls_i == DIPC_CLS_MOV_IMM);
   wire is_base = (cls_i == DIPC_CLS_NOP) || is_mov || (cls_i == DIPC_CLS_NOT) || is_alu ||
                  (cls_i == DIPC_CLS_TST) || (cls_i == DIPC_CLS_CMP) || (cls_i == DIPC_CLS_MULH);

   assign fuse_op_o  = is_alu || (cls_i == DIPC_CLS_MULH);
   assign pre_ubr_o  = is_base || (cls_i == DIPC_CLS_SLD) || (cls_i == DIPC_CLS_SST);
   assign pre_cbr_o  = (cls_i == DIPC_CLS_NOP) || is_mov || (cls_i == DIPC_CLS_MULH) ||
                       (cls_i == DIPC_CLS_EXT) || (cls_i == DIPC_CLS_SLD) || (cls_i == DIPC_CLS_SST);
   assign pre_sld_o  = is_base;
   assign flag_upd_o = is_alu || (cls_i == DIPC_CLS_NOT) || (cls_i == DIPC_CLS_TST) ||
                       (cls_i == DIPC_CLS_CMP);

endmodule : dipc_class_dec

// ==== src/dipc_pair_ctrl.sv ====
// dual-issue pairing control: decides pair issue and breakpoint resume stepping
`timescale 1ns/1ps
module dipc_pair_ctrl
   import dipc_pkg::*;
(
   // clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_n_i,
   input  wire logic                ce_i,
   // decode slots
   input  wire logic                dec_valid_i,
   input  wire dipc_pkg::dipc_cls_t first_cls_i,
   input  wire logic [4:0]          first_dst_i,
   input  wire logic                first_unaligned_tgt_i,
   input  wire logic                second_valid_i,
   input  wire dipc_pkg::dipc_cls_t second_cls_i,
   input  wire logic [4:0]          second_dst_i,
   // pipeline hazard state
   input  wire logic                ep_wb_pend_i,
   input  wire logic                prev_flag_upd_i,
   input  wire logic [1:0]          ldbuf_wb_wait_i,
   // breakpoint resume
   input  wire logic                resume_i,
   // issue outputs
   output logic                     pair_issue_o,
   output dipc_pkg::dipc_pk_t       pair_kind_o,
   output logic                     issue_o,
   output logic [1:0]               step_adv_o,
   output logic                     step_done_o,
   output logic                     step_active_o
);
   import dipc_pkg::*;

   logic     rst_s1_q;
   logic     rst_s2_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   wire rst_n = rst_s2_q;

   logic f_fuse, f_ubr, f_cbr, f_sld, f_flag;
   dipc_class_dec u_dec_first (
      .cls_i      (first_cls_i),
      .fuse_op_o  (),
      .pre_ubr_o  (f_ubr),
      .pre_cbr_o  (f_cbr),
      .pre_sld_o  (f_sld),
      .flag_upd_o (f_flag)
   );
   dipc_class_dec u_dec_second (
      .cls_i      (second_cls_i),
      .fuse_op_o  (f_fuse),
      .pre_ubr_o  (),
      .pre_cbr_o  (),
      .pre_sld_o  (),
      .flag_upd_o ()
   );

   // candidate pair kinds, second slot decides branch/load role
   wire both_ok   = dec_valid_i && second_valid_i && !first_unaligned_tgt_i;
   wire first_mov = (first_cls_i == DIPC_CLS_MOV_REG);
   wire fuse_ok   = first_mov && f_fuse && (first_dst_i == second_dst_i) &&
                    (first_dst_i != ZERO_REG_IDX);
   wire ubr_ok    = (second_cls_i == DIPC_CLS_UBR) && f_ubr;
   wire flag_haz  = f_flag || prev_flag_upd_i;
   wire cbr_ok    = (second_cls_i == DIPC_CLS_CBR) && f_cbr && !flag_haz;
   wire ldbuf_full = &ldbuf_wb_wait_i;
   wire sld_ok    = (second_cls_i == DIPC_CLS_SLD) && f_sld && !ep_wb_pend_i &&
                    !ldbuf_full;

   wire pair_w    = both_ok && (fuse_ok || ubr_ok || cbr_ok || sld_ok);
   wire dipc_pk_t kind_w = !pair_w ? DIPC_PK_NONE :
                           fuse_ok ? DIPC_PK_FUSE :
                           ubr_ok  ? DIPC_PK_UBR  :
                           cbr_ok  ? DIPC_PK_CBR  : DIPC_PK_SLD;

   // resume stepping
   dipc_st_t st_q, st_d;
   always_comb begin
      st_d = st_q;
      case (st_q)
         DIPC_ST_RUN:  st_d = st_q;
         DIPC_ST_HALT: if (resume_i) st_d = DIPC_ST_STEP;
         DIPC_ST_STEP: if (dec_valid_i) st_d = DIPC_ST_RUN;
         default:      st_d = DIPC_ST_RUN;
      endcase
      if (st_q == DIPC_ST_RUN && resume_i) st_d = DIPC_ST_STEP;
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= DIPC_ST_RUN;
      end else if (ce_i) begin
         st_q <= st_d;
      end
   end

   wire step_fire = (st_q == DIPC_ST_STEP) && dec_valid_i;

   assign pair_issue_o  = pair_w;
   assign pair_kind_o   = kind_w;
   assign issue_o       = dec_valid_i;
   assign step_adv_o    = !dec_valid_i ? 2'h0 : (pair_w ? 2'h2 : 2'h1);
   assign step_done_o   = step_fire;
   assign step_active_o = (st_q == DIPC_ST_STEP);

   AST_FUSE_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n)
      (pair_kind_o == DIPC_PK_FUSE) |-> (first_dst_i != ZERO_REG_IDX && first_dst_i == second_dst_i))
      else $error("fusion with zero or mismatched destination");
   AST_FUSE_ORDER: assert property (@(posedge clk_i) disable iff (!rst_n)
      (pair_kind_o == DIPC_PK_FUSE) |-> first_cls_i == DIPC_CLS_MOV_REG)
      else $error("fusion without move first");
   AST_UBR_SECOND: assert property (@(posedge clk_i) disable iff (!rst_n)
      (pair_kind_o == DIPC_PK_UBR) |-> second_cls_i == DIPC_CLS_UBR && first_cls_i != DIPC_CLS_UBR)
      else $error("bad branch pair");
   AST_CBR_FLAG: assert property (@(posedge clk_i) disable iff (!rst_n)
      (pair_kind_o == DIPC_PK_CBR) |-> !f_flag)
      else $error("cbr paired after flag update");
   AST_SLD_PRE: assert property (@(posedge clk_i) disable iff (!rst_n)
      (pair_kind_o == DIPC_PK_SLD) |-> first_cls_i != DIPC_CLS_SLD)
      else $error("sld paired after sld");
   AST_SECOND_POS: assert property (@(posedge clk_i) disable iff (!rst_n)
      pair_issue_o |-> first_cls_i != DIPC_CLS_UBR && first_cls_i != DIPC_CLS_CBR)
      else $error("branch in first position paired");
   AST_UNALIGNED: assert property (@(posedge clk_i) disable iff (!rst_n)
      first_unaligned_tgt_i |-> !pair_issue_o)
      else $error("pair after unaligned target");
   AST_EP_HAZ: assert property (@(posedge clk_i) disable iff (!rst_n)
      ep_wb_pend_i && second_cls_i == DIPC_CLS_SLD |-> !pair_issue_o)
      else $error("sld paired with pending pointer write");
   AST_FLAG_HAZ: assert property (@(posedge clk_i) disable iff (!rst_n)
      prev_flag_upd_i && second_cls_i == DIPC_CLS_CBR |-> !pair_issue_o)
      else $error("cbr paired under flag hazard");
   AST_LDBUF: assert property (@(posedge clk_i) disable iff (!rst_n)
      ldbuf_wb_wait_i == 2'h3 && second_cls_i == DIPC_CLS_SLD |-> !pair_issue_o)
      else $error("sld paired with load buffers full");
   AST_STEP: assert property (@(posedge clk_i) disable iff (!rst_n)
      step_done_o && ce_i |-> step_adv_o == (pair_issue_o ? 2'h2 : 2'h1) ##1 !step_active_o)
      else $error("resume step advance wrong");
   AST_PAIR_VALID: assert property (@(posedge clk_i) disable iff (!rst_n)
      pair_issue_o |-> dec_valid_i && second_valid_i && pair_kind_o != DIPC_PK_NONE)
      else $error("pair without two valid slots");

   // eligible pairs must issue
   wire chk_slots = dec_valid_i && second_valid_i && !first_unaligned_tgt_i;
   AST_FUSE_ALLOWED: assert property (@(posedge clk_i) disable iff (!rst_n)
      chk_slots && first_cls_i == DIPC_CLS_MOV_REG && first_dst_i == second_dst_i &&
      first_dst_i != ZERO_REG_IDX &&
      second_cls_i inside {DIPC_CLS_SAT, DIPC_CLS_LOGIC, DIPC_CLS_ADDSUB, DIPC_CLS_SHIFT, DIPC_CLS_MULH}
      |-> pair_kind_o == DIPC_PK_FUSE)
      else $error("eligible move fusion not issued");
   AST_UBR_ALLOWED: assert property (@(posedge clk_i) disable iff (!rst_n)
      chk_slots && second_cls_i == DIPC_CLS_UBR &&
      first_cls_i inside {DIPC_CLS_NOP, DIPC_CLS_MOV_REG, DIPC_CLS_MOV_IMM, DIPC_CLS_NOT, DIPC_CLS_SAT,
                          DIPC_CLS_LOGIC, DIPC_CLS_TST, DIPC_CLS_ADDSUB, DIPC_CLS_CMP, DIPC_CLS_SHIFT,
                          DIPC_CLS_MULH, DIPC_CLS_SLD, DIPC_CLS_SST}
      |-> pair_kind_o == DIPC_PK_UBR)
      else $error("eligible branch pair not issued");
   AST_CBR_ALLOWED: assert property (@(posedge clk_i) disable iff (!rst_n)
      chk_slots && second_cls_i == DIPC_CLS_CBR && !prev_flag_upd_i &&
      first_cls_i inside {DIPC_CLS_NOP, DIPC_CLS_MOV_REG, DIPC_CLS_MOV_IMM, DIPC_CLS_MULH, DIPC_CLS_EXT,
                          DIPC_CLS_SLD, DIPC_CLS_SST}
      |-> pair_kind_o == DIPC_PK_CBR)
      else $error("eligible conditional branch pair not issued");
   AST_SLD_ALLOWED: assert property (@(posedge clk_i) disable iff (!rst_n)
      chk_slots && second_cls_i == DIPC_CLS_SLD && !ep_wb_pend_i && ldbuf_wb_wait_i != 2'h3 &&
      first_cls_i inside {DIPC_CLS_NOP, DIPC_CLS_MOV_REG, DIPC_CLS_MOV_IMM, DIPC_CLS_NOT, DIPC_CLS_SAT,
                          DIPC_CLS_LOGIC, DIPC_CLS_TST, DIPC_CLS_ADDSUB, DIPC_CLS_CMP, DIPC_CLS_SHIFT,
                          DIPC_CLS_MULH}
      |-> pair_kind_o == DIPC_PK_SLD)
      else $error("eligible short load pair not issued");

   // issue count and resume stepping
   AST_NO_KIND: assert property (@(posedge clk_i) disable iff (!rst_n)
      !pair_issue_o |-> pair_kind_o == DIPC_PK_NONE)
      else $error("pair kind without pair issue");
   AST_IDLE_ADV: assert property (@(posedge clk_i) disable iff (!rst_n)
      !dec_valid_i |-> step_adv_o == 2'h0 && !pair_issue_o && !issue_o)
      else $error("advance without valid slot");
   AST_SINGLE_ADV: assert property (@(posedge clk_i) disable iff (!rst_n)
      dec_valid_i && !pair_issue_o |-> step_adv_o == 2'h1 && issue_o)
      else $error("single issue advance wrong");
   AST_TWO_ADV: assert property (@(posedge clk_i) disable iff (!rst_n)
      pair_issue_o |-> step_adv_o == 2'h2)
      else $error("pair issue advance wrong");
   AST_RESUME: assert property (@(posedge clk_i) disable iff (!rst_n)
      st_q == DIPC_ST_RUN && resume_i && ce_i |=> step_active_o)
      else $error("resume did not start a step");
   AST_STEP_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
      step_active_o && !dec_valid_i && ce_i |=> step_active_o)
      else $error("step dropped without issue");
   AST_STEP_DONE: assert property (@(posedge clk_i) disable iff (!rst_n)
      step_done_o |-> step_active_o && issue_o)
      else $error("step done outside a step");
   AST_CE_FREEZE: assert property (@(posedge clk_i) disable iff (!rst_n)
      !ce_i |=> $stable(st_q))
      else $error("step state moved with enable low");
   AST_ST_ONEHOT: assert property (@(posedge clk_i) disable iff (!rst_n)
      $onehot(st_q))
      else $error("step state not one-hot");

   COV_FUSE: cover property (@(posedge clk_i) disable iff (!rst_n) pair_kind_o == DIPC_PK_FUSE);
   COV_UBR:  cover property (@(posedge clk_i) disable iff (!rst_n) pair_kind_o == DIPC_PK_UBR);
   COV_CBR:  cover property (@(posedge clk_i) disable iff (!rst_n) pair_kind_o == DIPC_PK_CBR);
   COV_SLD:  cover property (@(posedge clk_i) disable iff (!rst_n) pair_kind_o == DIPC_PK_SLD);
   COV_STEP2: cover property (@(posedge clk_i) disable iff (!rst_n) step_done_o && pair_issue_o);

endmodule : dipc_pair_ctrl

// ==== src/dipc_pkg.sv ====
// package: instruction classes and constants for dual-issue pairing control
package dipc_pkg;

   // decoded instruction class presented by fetch/decode
   localparam int unsigned CLS_W = 5;
   typedef enum logic [CLS_W-1:0] {
      DIPC_CLS_NOP        = 5'h00,
      DIPC_CLS_MOV_REG    = 5'h01,
      DIPC_CLS_MOV_IMM    = 5'h02,
      DIPC_CLS_NOT        = 5'h03,
      DIPC_CLS_SAT        = 5'h04,
      DIPC_CLS_LOGIC      = 5'h05,
      DIPC_CLS_TST        = 5'h06,
      DIPC_CLS_ADDSUB     = 5'h07,
      DIPC_CLS_CMP        = 5'h08,
      DIPC_CLS_SHIFT      = 5'h09,
      DIPC_CLS_MULH       = 5'h0a,
      DIPC_CLS_EXT        = 5'h0b,
      DIPC_CLS_SLD        = 5'h0c,
      DIPC_CLS_SST        = 5'h0d,
      DIPC_CLS_UBR        = 5'h0e,
      DIPC_CLS_CBR        = 5'h0f,
      DIPC_CLS_OTHER      = 5'h10
   } dipc_cls_t;

   localparam int unsigned    REG_W          = 5;
   localparam logic [4:0]     ZERO_REG_IDX   = 5'h00;
   localparam logic [4:0]     ELEM_PTR_IDX   = 5'h1e;
   localparam int unsigned    LDBUF_N        = 2;

   // pair kinds reported with a pair issue
   typedef enum logic [2:0] {
      DIPC_PK_NONE = 3'h0,
      DIPC_PK_FUSE = 3'h1,
      DIPC_PK_UBR  = 3'h2,
      DIPC_PK_CBR  = 3'h3,
      DIPC_PK_SLD  = 3'h4
   } dipc_pk_t;

   // resume step states, one-hot
   typedef enum logic [2:0] {
      DIPC_ST_RUN  = 3'b001,
      DIPC_ST_STEP = 3'b010,
      DIPC_ST_HALT = 3'b100
   } dipc_st_t;

endpackage : dipc_pkg
